// >>> rtl/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// register selects on the system register port
`define PMC_SEL_PRESENCE  2'h0
`define PMC_SEL_CTRL      2'h1
`define PMC_SEL_CTRL_64   2'h2
`define PMC_SEL_CTRL_EXT  2'h3

// extended event presence: bits 11, 9 and 6..0 set
`define PMC_PRESENCE_VAL  32'h00000a7f

// identity codes, arbitrary values
`define PMC_IMPL_CODE     8'h5a
`define PMC_PART_CODE     8'h3c

`define PMC_NUM_CTR_FLD   5'h06
`define PMC_NUM_CTR       6

// control field positions
`define PMC_IMPL_MSB      31
`define PMC_IMPL_LSB      24
`define PMC_PART_MSB      23
`define PMC_PART_LSB      16
`define PMC_NCTR_MSB      15
`define PMC_NCTR_LSB      11
`define PMC_BIT_LONG_CYC  6
`define PMC_BIT_DBG_GATE  5
`define PMC_BIT_X         4
`define PMC_BIT_D         3
`define PMC_BIT_C         2
`define PMC_BIT_P         1
`define PMC_BIT_E         0
`define PMC_BIT_CYC_OVF   31

// writable field reset values, packed as long cycle, debug gate, export, divider, enable
`define PMC_CTRL_RST      5'h00
// fill used when the core does not boot into the 32-bit level, arbitrary
`define PMC_CTRL_UNK      5'h15

// divide-by-64 prescaler terminal value
`define PMC_DIV_LAST      6'h3f

`endif

// >>> rtl/pmc_pkg.sv
package pmc_pkg;

  typedef struct packed {
    logic long_cycle_select;
    logic debug_prohibit_gate;
    logic x;
    logic d;
    logic e;
  } pmc_ctrl_t;

  typedef enum logic {
    PMC_ST_BOOT,
    PMC_ST_RUN
  } pmc_boot_t;

endpackage

// >>> rtl/pmc_cyc_if.sv
`timescale 1ns/1ps
interface pmc_cyc_if;
  logic        inc_en;
  logic        div64;
  logic        long_cycle;
  logic        clear;
  logic [63:0] count;
  logic        ovf_pulse;

  modport ctl (output inc_en, output div64, output long_cycle, output clear,
               input count, input ovf_pulse);
  modport ctr (input inc_en, input div64, input long_cycle, input clear,
               output count, output ovf_pulse);
endinterface

// >>> rtl/pmc_cycle_counter.sv
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_cycle_counter
  import pmc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  pmc_cyc_if.ctr    cyc
);

  logic [63:0] cnt_q;
  logic [63:0] cnt_d;
  logic [5:0]  div_q;
  logic [5:0]  div_d;
  logic        ovf_q;
  logic        ovf_d;
  logic        tick;

  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    tick  = 1'b0;
    if (cyc.inc_en) begin
      div_d = (div_q == `PMC_DIV_LAST) ? 6'h00 : div_q + 6'h01;
      tick  = cyc.div64 ? (div_q == `PMC_DIV_LAST) : 1'b1;
    end
    if (cyc.clear) begin
      cnt_d = 64'h0;
    end else if (tick) begin
      cnt_d = cnt_q + 64'h1;
      // overflow boundary chosen by long cycle select
      if (cyc.long_cycle) begin
        ovf_d = cnt_q[63] & ~cnt_d[63];
      end else begin
        ovf_d = cnt_q[31] & ~cnt_d[31];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 64'h0;
      div_q <= 6'h00;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
      ovf_q <= ovf_d;
    end
  end

  assign cyc.count     = cnt_q;
  assign cyc.ovf_pulse = ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_CYC_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cyc.clear |=> cnt_q == 64'h0)
    else $error("cycle counter not zero after clear");

  AST_CYC_DIV64: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cyc.inc_en && cyc.div64 && !cyc.clear && div_q != `PMC_DIV_LAST)
      |=> cnt_q == $past(cnt_q))
    else $error("divided cycle counter moved off its 64th cycle");

  AST_CYC_OVF32: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!cyc.long_cycle && !cyc.clear && tick && cnt_q[31:0] == 32'hffffffff)
      |=> ovf_q)
    else $error("32-bit boundary overflow missed");

  AST_CYC_OVF64: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cyc.long_cycle && tick && !cyc.clear && cnt_q[63] == 1'b0) |=> !ovf_q)
    else $error("overflow raised below the 64-bit boundary");

  COV_CYC_DIV: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    cyc.div64 && tick);

endmodule

// >>> rtl/pmc_monitor_control.sv
// Functional notes
// - extended event presence register is read-only, one bit per implemented event
// - presence bits 11, 9, 6..0 read one; others read zero
// - top byte returns fixed implementer code; writes ignored
// - bits 23..16 return fixed part code
// - bits 15..11 report six counters; bits 10..7 read zero
// - long cycle select zero: overflow when cycle bit 31 wraps
// - long cycle select one: overflow only when cycle bit 63 wraps
// - debug prohibit set stops cycle counter unless debug permitted
// - export enable gates event export; none while counting prohibited
// - export enable does not affect overflow interrupt or cross-trigger signalling
// - divider set: cycle counter increments once per 64 clocks
// - writing one to cycle clear zeroes cycle counter; reads zero
// - cycle clear leaves cycle overflow flag unchanged
// - writing one to event clear zeroes accessible event counters; reads zero
// - non-secure levels 0,1 spare hypervisor counters; levels 2,3 clear all
// - event clear leaves overflow flags unchanged
// - global enable zero holds level-1 counters and cycle counter disabled
// - global enable does not affect hypervisor-reserved counters
// - defined reset values apply only when booting into 32-bit level
// - one control register serves secure and non-secure states
// - low seven control bits shared by all register views
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_monitor_control
  import pmc_pkg::*;
(
  input  wire logic         I_CLK,
  input  wire logic         I_RST_N,
  input  wire logic [1:0]   I_SYSREG_SEL,
  input  wire logic         I_SYSREG_WR,
  input  wire logic         I_SYSREG_RD,
  input  wire logic [31:0]  I_SYSREG_WDATA,
  input  wire logic [1:0]   I_EL,
  input  wire logic         I_NONSECURE,
  input  wire logic [4:0]   I_HYP_PARTITION,
  input  wire logic         I_BOOT_AARCH32,
  input  wire logic         I_NIDEN,
  input  wire logic [5:0]   I_CNT_EN,
  input  wire logic [5:0]   I_EVENTS,
  input  wire logic         I_OVF_CLR,
  input  wire logic [31:0]  I_OVF_CLR_MASK,
  output logic      [31:0]  O_SYSREG_RDATA,
  output logic              O_SYSREG_RVALID,
  output logic      [63:0]  O_CYCLE_COUNT,
  output logic      [191:0] O_EVENT_COUNT,
  output logic      [31:0]  O_OVF_STATUS,
  output logic              O_OVF_CTI,
  output logic      [5:0]   O_EXPORT_EVENTS
);

  localparam int NC = `PMC_NUM_CTR;

  ////////////////////////////////////////////////////////////////////////////
  // debug permission pin synchroniser
  logic [2:0] niden_sync_q;
  logic [2:0] niden_sync_d;
  logic       niden_q;
  logic       niden_d;

  always_comb begin
    niden_sync_d = {niden_sync_q[1:0], I_NIDEN};
    niden_d      = (niden_sync_q[1] == niden_sync_q[2]) ? niden_sync_q[2] : niden_q;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      niden_sync_q <= 3'h0;
      niden_q      <= 1'b0;
    end else begin
      niden_sync_q <= niden_sync_d;
      niden_q      <= niden_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, single copy for all states and views
  pmc_boot_t boot_q;
  pmc_boot_t boot_d;
  pmc_ctrl_t ctrl_q;
  pmc_ctrl_t ctrl_d;
  logic      ctrl_sel;
  logic      wr_ok;
  logic      cyc_clr;
  logic      ev_clr;

  assign ctrl_sel = (I_SYSREG_SEL == `PMC_SEL_CTRL) || (I_SYSREG_SEL == `PMC_SEL_CTRL_64)
                 || (I_SYSREG_SEL == `PMC_SEL_CTRL_EXT);
  assign wr_ok    = I_SYSREG_WR && ctrl_sel && (boot_q == PMC_ST_RUN);
  assign cyc_clr  = wr_ok && I_SYSREG_WDATA[`PMC_BIT_C];
  assign ev_clr   = wr_ok && I_SYSREG_WDATA[`PMC_BIT_P];

  always_comb begin
    boot_d = boot_q;
    ctrl_d = ctrl_q;
    unique case (boot_q)
      PMC_ST_BOOT: begin
        boot_d = PMC_ST_RUN;
        ctrl_d = I_BOOT_AARCH32 ? `PMC_CTRL_RST : `PMC_CTRL_UNK;
      end
      PMC_ST_RUN: begin
        if (wr_ok) begin
          // identity and count fields are not stored, so writes drop there
          ctrl_d.long_cycle_select   = I_SYSREG_WDATA[`PMC_BIT_LONG_CYC];
          ctrl_d.debug_prohibit_gate = I_SYSREG_WDATA[`PMC_BIT_DBG_GATE];
          ctrl_d.x  = I_SYSREG_WDATA[`PMC_BIT_X];
          ctrl_d.d  = I_SYSREG_WDATA[`PMC_BIT_D];
          ctrl_d.e  = I_SYSREG_WDATA[`PMC_BIT_E];
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      boot_q <= PMC_ST_BOOT;
      ctrl_q <= `PMC_CTRL_RST;
    end else begin
      boot_q <= boot_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] ctrl_view;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        rvalid_q;

  always_comb begin
    ctrl_view = 32'h0;
    ctrl_view[`PMC_IMPL_MSB:`PMC_IMPL_LSB] = `PMC_IMPL_CODE;
    ctrl_view[`PMC_PART_MSB:`PMC_PART_LSB] = `PMC_PART_CODE;
    ctrl_view[`PMC_NCTR_MSB:`PMC_NCTR_LSB] = `PMC_NUM_CTR_FLD;
    ctrl_view[`PMC_BIT_LONG_CYC] = ctrl_q.long_cycle_select;
    ctrl_view[`PMC_BIT_DBG_GATE] = ctrl_q.debug_prohibit_gate;
    ctrl_view[`PMC_BIT_X]  = ctrl_q.x;
    ctrl_view[`PMC_BIT_D]  = ctrl_q.d;
    ctrl_view[`PMC_BIT_E]  = ctrl_q.e; // clear bits stay zero
    rdata_d = rdata_q;
    if (I_SYSREG_RD) begin
      rdata_d = (I_SYSREG_SEL == `PMC_SEL_PRESENCE) ? `PMC_PRESENCE_VAL : ctrl_view;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q  <= 32'h0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= I_SYSREG_RD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle counter
  pmc_cyc_if cyc ();
  logic cyc_run;

  assign cyc_run        = ctrl_q.e && !(ctrl_q.debug_prohibit_gate && !niden_q);
  assign cyc.inc_en     = cyc_run;
  assign cyc.div64      = ctrl_q.d;
  assign cyc.long_cycle = ctrl_q.long_cycle_select;
  assign cyc.clear      = cyc_clr;

  pmc_cycle_counter u_cycle (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .cyc     (cyc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event counters and overflow status
  logic [31:0] evcnt_q [NC];
  logic [31:0] evcnt_d [NC];
  logic [NC-1:0] reserved;
  logic [NC-1:0] ev_inc;
  logic [NC-1:0] ev_wrap;
  logic [NC-1:0] ev_clr_mask;
  logic          spare_hyp;
  logic [31:0]   ovf_d;
  logic [31:0]   ovf_q;
  logic [31:0]   ovf_set;

  assign spare_hyp = I_NONSECURE && (I_EL < 2'h2);

  always_comb begin
    ovf_set = 32'h0;
    for (int i = 0; i < NC; i++) begin
      reserved[i]    = (5'(i) >= I_HYP_PARTITION);
      ev_inc[i]      = (reserved[i] || ctrl_q.e) && I_CNT_EN[i] && I_EVENTS[i];
      ev_clr_mask[i] = ev_clr && !(spare_hyp && reserved[i]);
      ev_wrap[i]     = ev_inc[i] && !ev_clr_mask[i] && (evcnt_q[i] == 32'hffffffff);
      evcnt_d[i]     = evcnt_q[i];
      if (ev_clr_mask[i]) begin
        evcnt_d[i] = 32'h0;
      end else if (ev_inc[i]) begin
        evcnt_d[i] = evcnt_q[i] + 32'h1;
      end
      ovf_set[i] = ev_wrap[i];
    end
    ovf_set[`PMC_BIT_CYC_OVF] = cyc.ovf_pulse;
    // counter clears never touch these flags; the masked overflow clear drops them, and a set in the clear cycle wins
    ovf_d = (ovf_q & ~({32{I_OVF_CLR}} & I_OVF_CLR_MASK)) | ovf_set;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NC; i++) begin
        evcnt_q[i] <= 32'h0;
      end
      ovf_q <= 32'h0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        evcnt_q[i] <= evcnt_d[i];
      end
      ovf_q <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event export toward trace
  logic [5:0] export_d;
  logic [5:0] export_q;

  assign export_d = (ctrl_q.x && niden_q) ? I_EVENTS : 6'h00;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      export_q <= 6'h00;
    end else begin
      export_q <= export_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign O_SYSREG_RDATA  = rdata_q;
  assign O_SYSREG_RVALID = rvalid_q;
  assign O_CYCLE_COUNT   = cyc.count;
  assign O_OVF_STATUS    = ovf_q;
  assign O_OVF_CTI       = |ovf_q;
  assign O_EXPORT_EVENTS = export_q;

  always_comb begin
    for (int i = 0; i < NC; i++) begin
      O_EVENT_COUNT[32*i +: 32] = evcnt_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PRESENCE_READ: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_SYSREG_RD && I_SYSREG_SEL == `PMC_SEL_PRESENCE)
      |=> O_SYSREG_RVALID && O_SYSREG_RDATA == 32'h00000a7f)
    else $error("presence register read wrong value");

  AST_CTRL_ID_READ: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_SYSREG_RD && I_SYSREG_SEL == `PMC_SEL_CTRL)
      |=> O_SYSREG_RDATA[15:7] == 9'h060 && O_SYSREG_RDATA[2:1] == 2'h0)
    else $error("counter count or reserved bits wrong");

  AST_IMPL_FIXED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_SYSREG_RD && I_SYSREG_SEL == `PMC_SEL_CTRL_64)
      |=> O_SYSREG_RDATA[31:16] == {`PMC_IMPL_CODE, `PMC_PART_CODE})
    else $error("identity fields changed");

  AST_VIEWS_SHARED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (wr_ok && I_SYSREG_SEL == `PMC_SEL_CTRL_EXT) ##1 (I_SYSREG_RD && I_SYSREG_SEL == `PMC_SEL_CTRL)
      |=> O_SYSREG_RDATA[6:3] == $past(I_SYSREG_WDATA[6:3], 2))
    else $error("control views do not share storage");

  AST_GLOBAL_DISABLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (!ctrl_q.e && !cyc_clr) |=> O_CYCLE_COUNT == $past(O_CYCLE_COUNT))
    else $error("cycle counter moved while globally disabled");

  AST_DEBUG_PROHIBIT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (ctrl_q.debug_prohibit_gate && !niden_q && !cyc_clr)
      |=> O_CYCLE_COUNT == $past(O_CYCLE_COUNT))
    else $error("cycle counter ran while debug prohibited");

  AST_EXPORT_GATE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (!ctrl_q.x || !niden_q) |=> O_EXPORT_EVENTS == 6'h00)
    else $error("events exported while export off or prohibited");

  AST_CLR_KEEPS_OVF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (ev_clr && !I_OVF_CLR) |=> (O_OVF_STATUS & $past(O_OVF_STATUS)) == $past(O_OVF_STATUS))
    else $error("counter clear dropped an overflow flag");

  AST_CYC_CLR_KEEPS_OVF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (cyc_clr && !I_OVF_CLR && O_OVF_STATUS[31]) |=> O_OVF_STATUS[31])
    else $error("cycle clear dropped its overflow flag");

  AST_HYP_SPARED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (ev_clr && spare_hyp && reserved[5] && !ev_inc[5])
      |=> O_EVENT_COUNT[191:160] == $past(O_EVENT_COUNT[191:160]))
    else $error("reserved counter cleared from low level");

  AST_EV_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (ev_clr && !spare_hyp) |=> O_EVENT_COUNT == 192'h0)
    else $error("event counters not cleared");

  COV_CYC_OVF: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_OVF_STATUS[31]);
  COV_EV_OVF: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    |ovf_set[5:0]);
  COV_EXPORT: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    |O_EXPORT_EVENTS);

endmodule

// >>> sim/perf_monitor_control_tb.sv
`timescale 1ns/1ps
`include "pmc_cfg.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end

module perf_monitor_control_tb;
  logic         clk;
  logic         rst_n;
  logic [1:0]   sel;
  logic         wr;
  logic         rd;
  logic [31:0]  wdata;
  logic [1:0]   el;
  logic         ns;
  logic [4:0]   part;
  logic         boot;
  logic         niden;
  logic [5:0]   cnt_en;
  logic [5:0]   events;
  logic [31:0]  rdata;
  logic         rvalid;
  logic [63:0]  cyc;
  logic [191:0] evc;
  logic [31:0]  ovf;
  logic         cti;
  logic [5:0]   exp_ev;
  int           error_cnt;
  int           compares;
  logic [31:0]  v;
  logic [63:0]  a;
  logic [191:0] snap;

  pmc_monitor_control u_dut (
    .I_CLK           (clk),
    .I_RST_N         (rst_n),
    .I_SYSREG_SEL    (sel),
    .I_SYSREG_WR     (wr),
    .I_SYSREG_RD     (rd),
    .I_SYSREG_WDATA  (wdata),
    .I_EL            (el),
    .I_NONSECURE     (ns),
    .I_HYP_PARTITION (part),
    .I_BOOT_AARCH32  (boot),
    .I_NIDEN         (niden),
    .I_CNT_EN        (cnt_en),
    .I_EVENTS        (events),
    .I_OVF_CLR       (1'b0),
    .I_OVF_CLR_MASK  (32'h00000000),
    .O_SYSREG_RDATA  (rdata),
    .O_SYSREG_RVALID (rvalid),
    .O_CYCLE_COUNT   (cyc),
    .O_EVENT_COUNT   (evc),
    .O_OVF_STATUS    (ovf),
    .O_OVF_CTI       (cti),
    .O_EXPORT_EVENTS (exp_ev)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [6:0] lo);
    return {`PMC_IMPL_CODE, `PMC_PART_CODE, `PMC_NUM_CTR_FLD, 4'h0, lo};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset(input logic b);
    boot  = b;
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(2);
  endtask

  task automatic wr_reg(input logic [1:0] s, input logic [31:0] d);
    sel   = s;
    wdata = d;
    wr    = 1'b1;
    tick(1);
    wr    = 1'b0;
  endtask

  // read data only counts when the valid pulse is up
  task automatic rd_reg(input logic [1:0] s, output logic [31:0] d);
    sel = s;
    rd  = 1'b1;
    tick(1);
    rd  = 1'b0;
    d   = (rvalid === 1'b1) ? rdata : 32'hxxxxxxxx;
    tick(1);
  endtask

  task automatic run_diff(input int n, input logic [63:0] e);
    a = cyc;
    tick(n);
    `CHK(cyc - a, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ident;
    rd_reg(`PMC_SEL_PRESENCE, v);
    `CHK(v, 32'h00000a7f)
    rd_reg(`PMC_SEL_CTRL, v);
    `CHK(v, ctl(7'h00))
    wr_reg(`PMC_SEL_PRESENCE, 32'h00000000);
    rd_reg(`PMC_SEL_PRESENCE, v);
    `CHK(v, 32'h00000a7f)
  endtask

  task automatic t_fields;
    wr_reg(`PMC_SEL_CTRL, 32'hffffffff);
    rd_reg(`PMC_SEL_CTRL, v);
    `CHK(v, ctl(7'h79))
    rd_reg(`PMC_SEL_CTRL_64, v);
    `CHK(v[6:0], 7'h79)
    rd_reg(`PMC_SEL_CTRL_EXT, v);
    `CHK(v[6:0], 7'h79)
    wr_reg(`PMC_SEL_CTRL_EXT, 32'h00000000);
    rd_reg(`PMC_SEL_CTRL, v);
    `CHK(v, ctl(7'h00))
  endtask

  task automatic t_cycle;
    wr_reg(`PMC_SEL_CTRL, 32'h00000001);
    tick(2);
    run_diff(10, 64'h000000000000000a);
    wr_reg(`PMC_SEL_CTRL, 32'h00000009);
    tick(2);
    run_diff(128, 64'h0000000000000002);
    wr_reg(`PMC_SEL_CTRL, 32'h00000000);
    tick(2);
    run_diff(10, 64'h0000000000000000);
    wr_reg(`PMC_SEL_CTRL, 32'h00000005);
    tick(1);
    `CHK(cyc, 64'h0000000000000001)
    `CHK(ovf[31], 1'b0)
    wr_reg(`PMC_SEL_CTRL, 32'h00000041);
    tick(2);
    run_diff(10, 64'h000000000000000a);
  endtask

  task automatic t_dp;
    niden = 1'b0;
    wr_reg(`PMC_SEL_CTRL, 32'h00000021);
    tick(5);
    run_diff(10, 64'h0000000000000000);
    niden = 1'b1;
    tick(5);
    run_diff(10, 64'h000000000000000a);
    niden = 1'b0;
    wr_reg(`PMC_SEL_CTRL, 32'h00000001);
    tick(5);
    run_diff(10, 64'h000000000000000a);
  endtask

  task automatic t_export;
    niden  = 1'b1;
    events = 6'h2a;
    wr_reg(`PMC_SEL_CTRL, 32'h00000010);
    tick(5);
    `CHK(exp_ev, 6'h2a)
    events = 6'h15;
    tick(1);
    `CHK(exp_ev, 6'h15)
    niden = 1'b0;
    tick(5);
    `CHK(exp_ev, 6'h00)
    niden = 1'b1;
    tick(5);
    `CHK(exp_ev, 6'h15)
    wr_reg(`PMC_SEL_CTRL, 32'h00000000);
    tick(2);
    `CHK(exp_ev, 6'h00)
    events = 6'h00;
  endtask

  task automatic t_evclr;
    cnt_en = 6'h3f;
    wr_reg(`PMC_SEL_CTRL, 32'h00000001);
    events = 6'h3f;
    tick(20);
    events = 6'h00;
    tick(2);
    snap = evc;
    `CHK(snap[31:0], 32'h00000014)
    part = 5'h03;
    ns   = 1'b1;
    el   = 2'h1;
    wr_reg(`PMC_SEL_CTRL, 32'h00000003);
    tick(1);
    for (int i = 0; i < 6; i++) begin
      `CHK(evc[32*i +: 32], (i < 3) ? 32'h00000000 : snap[32*i +: 32])
    end
    `CHK(ovf, 32'h00000000)
    `CHK(cti, 1'b0)
    el = 2'h2;
    wr_reg(`PMC_SEL_CTRL, 32'h00000003);
    tick(1);
    `CHK(evc, 192'h0)
    wr_reg(`PMC_SEL_CTRL, 32'h00000000);
    events = 6'h3f;
    tick(5);
    events = 6'h00;
    tick(2);
    `CHK(evc[31:0], 32'h00000000)
    `CHK(evc[127:96], 32'h00000005)
  endtask

  task automatic t_boot;
    do_reset(1'b0);
    rd_reg(`PMC_SEL_CTRL, v);
    `CHK(v, ctl(7'h51))
  endtask

  task automatic close_out;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    compares  = 0;
    sel       = 2'h0;
    wr        = 1'b0;
    rd        = 1'b0;
    wdata     = 32'h00000000;
    el        = 2'h0;
    ns        = 1'b0;
    part      = 5'h06;
    niden     = 1'b0;
    cnt_en    = 6'h00;
    events    = 6'h00;
    do_reset(1'b1);
    t_ident();
    t_fields();
    t_cycle();
    t_dp();
    t_export();
    t_evclr();
    t_boot();
    close_out();
  end
endmodule
